// ===== pkg/ptm_map.svh
// Register offsets, field positions, reset values and ratios of the timer
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PTM_ADDR_EVENT_CFG 16'hffc0
`define PTM_ADDR_SRC_WAVE 16'hffc1
`define PTM_ADDR_T0_CTRL 16'hffc2
`define PTM_ADDR_T1_CTRL 16'hffc3
`define PTM_ADDR_T0_RLD_LO 16'hffc4
`define PTM_ADDR_T0_RLD_HI 16'hffc5
`define PTM_ADDR_T1_RLD_LO 16'hffc6
`define PTM_ADDR_T1_RLD_HI 16'hffc7
`define PTM_ADDR_T0_CNT_LO 16'hffc8
`define PTM_ADDR_T0_CNT_HI 16'hffc9
`define PTM_ADDR_T1_CNT_LO 16'hffca
`define PTM_ADDR_T1_CNT_HI 16'hffcb
`define PTM_ADDR_IRQ_MASK 16'hffe2
`define PTM_ADDR_IRQ_FLAG 16'hfff2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTM_EVT_POL_BIT 0
`define PTM_EVT_NR_BIT 1
`define PTM_EVT_MODE_BIT 2
`define PTM_SRC_T0_BIT 0
`define PTM_SRC_T1_BIT 1
`define PTM_WAVE_EN_BIT 2
`define PTM_WAVE_CH_BIT 3
`define PTM_CTRL_RUN_BIT 0
`define PTM_CTRL_RLD_BIT 1
`define PTM_CTRL_DIV_LSB 2

// ----------------------------------------------------------------------
// Reset values and prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------------
`define PTM_NIB_RESET 4'h0
`define PTM_CNT_RESET 8'h00
`define PTM_LAST_DIV1 8'h00
`define PTM_LAST_DIV4 8'h03
`define PTM_LAST_DIV32 8'h1f
`define PTM_LAST_DIV256 8'hff

`endif

// ===== pkg/ptm_pkg.sv
// Types shared by the dual programmable timer
package ptm_pkg;
  typedef logic [15:0] ptm_addr_t;
  typedef logic [3:0] ptm_nib_t;
  typedef logic [7:0] ptm_cnt_t;
  typedef logic [1:0] ptm_div_t;
endpackage

// ===== hdl/ptm_timer.sv
// Dual 8-bit programmable timer: prescalers, counters, flags, square wave
//
// Operation
// - Each timer has its own prescaler with independent source and ratio.
// - Source select 0 takes the slow oscillator, 1 the fast oscillator.
// - Ratio code 11 divides by 256, 10 by 32, 01 by 4, 00 by 1.
// - Prescaler runs only with run bit set; counter decrements on its output.
// - In event mode timer 0 ignores its source and ratio settings.
// - Underflow sets that timer's interrupt flag and raises a request.
// - Mask bit 0 blocks the request; the flag is still set.
// - Square wave toggles once per underflow of the selected timer.
// - Channel select 0 picks timer 0, 1 picks timer 1.
// - Output enable 1 puts the wave on the pin; 0 holds it high.
// - Enable gates the wave directly, so a half-cycle glitch may occur.
// - Timer 1 underflows halved clock the serial unit while it runs.
// - Event config holds polarity, noise reject, event mode; bit 3 reads 0.
// - Source and wave register holds both source selects, enable, channel.
// - Control holds run, write-only reload strobe reading 0, ratio field.
// - Reload values split into low and high nibbles at paired addresses.
// - Writing 1 to the reload strobe copies reload data into the counter.
// - On underflow the counter reloads and keeps counting down.
// - Run and stop leave the count untouched; counting resumes from it.
// - Reading the low count nibble latches the high nibble.
`timescale 1ns/100ps
`include "ptm_map.svh"

module ptm_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire ptm_pkg::ptm_addr_t addr,
  input wire ptm_pkg::ptm_nib_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output ptm_pkg::ptm_nib_t rd_data,
  input wire logic slow_osc_clk,
  input wire logic fast_osc_clk,
  input wire logic t0_event_tick,
  output logic t0_event_mode,
  output logic t0_noise_reject_en,
  output logic t0_edge_polarity,
  output logic t0_run,
  output logic t1_run,
  output logic t0_underflow,
  output logic t1_underflow,
  output logic t0_irq_req,
  output logic t1_irq_req,
  output logic square_wave,
  output logic shared_out_pin,
  output logic serial_clk
);
  import ptm_pkg::*;

  // --------------------------------------------------------------------
  // Terminal count of the prescaler for a ratio code
  // --------------------------------------------------------------------
  function automatic ptm_cnt_t div_last(input ptm_div_t code);
    ptm_cnt_t last;
    last = `PTM_LAST_DIV1;
    unique case (code)
      2'h0: last = `PTM_LAST_DIV1;
      2'h1: last = `PTM_LAST_DIV4;
      2'h2: last = `PTM_LAST_DIV32;
      2'h3: last = `PTM_LAST_DIV256;
    endcase
    return last;
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic evt_pol_reg;
  logic evt_nr_reg;
  logic evt_mode_reg;
  logic [1:0] src_sel_reg;
  logic wave_en_reg;
  logic wave_ch_reg;
  logic [1:0] run_reg;
  ptm_div_t div_reg [2];
  ptm_cnt_t reload_reg [2];
  ptm_cnt_t cnt_reg [2];
  ptm_cnt_t pre_reg [2];
  ptm_nib_t hi_hold_reg [2];
  logic [1:0] irq_en_reg;
  logic [1:0] irq_flag_reg;
  logic wave_reg;
  logic serial_reg;
  ptm_nib_t rd_data_reg;
  ptm_nib_t rd_data_next;

  // --------------------------------------------------------------------
  // Oscillator pins: two-stage sync, then a rising-edge detector
  // --------------------------------------------------------------------
  logic [1:0] slow_sync_reg;
  logic [1:0] fast_sync_reg;
  logic slow_last_reg;
  logic fast_last_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      slow_sync_reg <= 2'h0;
      fast_sync_reg <= 2'h0;
      slow_last_reg <= 1'b0;
      fast_last_reg <= 1'b0;
    end else if (ce) begin
      slow_sync_reg <= {slow_sync_reg[0], slow_osc_clk};
      fast_sync_reg <= {fast_sync_reg[0], fast_osc_clk};
      slow_last_reg <= slow_sync_reg[1];
      fast_last_reg <= fast_sync_reg[1];
    end
  end

  // Oscillator pins must run below half the clk rate; faster edges merge
  // in the synchroniser and ticks are lost
  wire slow_tick = slow_sync_reg[1] & ~slow_last_reg;
  wire fast_tick = fast_sync_reg[1] & ~fast_last_reg;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire wr_evt = wr_en && (addr == `PTM_ADDR_EVENT_CFG);
  wire wr_src = wr_en && (addr == `PTM_ADDR_SRC_WAVE);
  wire [1:0] wr_ctrl = {wr_en && (addr == `PTM_ADDR_T1_CTRL),
                        wr_en && (addr == `PTM_ADDR_T0_CTRL)};
  wire [1:0] wr_rld_lo = {wr_en && (addr == `PTM_ADDR_T1_RLD_LO),
                          wr_en && (addr == `PTM_ADDR_T0_RLD_LO)};
  wire [1:0] wr_rld_hi = {wr_en && (addr == `PTM_ADDR_T1_RLD_HI),
                          wr_en && (addr == `PTM_ADDR_T0_RLD_HI)};
  wire wr_mask = wr_en && (addr == `PTM_ADDR_IRQ_MASK);
  wire wr_flag = wr_en && (addr == `PTM_ADDR_IRQ_FLAG);
  wire [1:0] rd_cnt_lo = {rd_en && (addr == `PTM_ADDR_T1_CNT_LO),
                          rd_en && (addr == `PTM_ADDR_T0_CNT_LO)};
  wire [1:0] reload_hit = wr_ctrl & {2{wr_data[`PTM_CTRL_RLD_BIT]}};

  // --------------------------------------------------------------------
  // Count clock selection
  // --------------------------------------------------------------------
  wire [1:0] src_tick;
  wire [1:0] pre_wrap;
  wire [1:0] count_pulse;
  wire [1:0] uflow;

  assign src_tick[0] = src_sel_reg[0] ? fast_tick : slow_tick;
  assign src_tick[1] = src_sel_reg[1] ? fast_tick : slow_tick;
  assign pre_wrap[0] = pre_reg[0] == div_last(div_reg[0]);
  assign pre_wrap[1] = pre_reg[1] == div_last(div_reg[1]);
  assign count_pulse[0] = run_reg[0] &&
    (evt_mode_reg ? t0_event_tick : (src_tick[0] && pre_wrap[0]));
  // Timer 1 has no event input, so it always counts prescaler output
  assign count_pulse[1] = run_reg[1] && src_tick[1] && pre_wrap[1];
  // A zero reload gives one underflow on every count pulse
  // Strobe wins over a count landing in the same cycle
  assign uflow = count_pulse & ~reload_hit &
                 {cnt_reg[1] == 8'h00, cnt_reg[0] == 8'h00};

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_pol_reg <= 1'b0;
      evt_nr_reg <= 1'b0;
      evt_mode_reg <= 1'b0;
      src_sel_reg <= 2'h0;
      wave_en_reg <= 1'b0;
      wave_ch_reg <= 1'b0;
      irq_en_reg <= 2'h0;
    end else if (ce) begin
      if (wr_evt) begin
        evt_pol_reg <= wr_data[`PTM_EVT_POL_BIT];
        evt_nr_reg <= wr_data[`PTM_EVT_NR_BIT];
        evt_mode_reg <= wr_data[`PTM_EVT_MODE_BIT];
      end
      if (wr_src) begin
        src_sel_reg[0] <= wr_data[`PTM_SRC_T0_BIT];
        src_sel_reg[1] <= wr_data[`PTM_SRC_T1_BIT];
        wave_en_reg <= wr_data[`PTM_WAVE_EN_BIT];
        wave_ch_reg <= wr_data[`PTM_WAVE_CH_BIT];
      end
      if (wr_mask) begin
        irq_en_reg <= wr_data[1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-timer control, reload data, prescaler and down counter
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      run_reg <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        div_reg[i] <= 2'h0;
        reload_reg[i] <= `PTM_CNT_RESET;
        cnt_reg[i] <= `PTM_CNT_RESET;
        pre_reg[i] <= `PTM_CNT_RESET;
      end
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctrl[i]) begin
          run_reg[i] <= wr_data[`PTM_CTRL_RUN_BIT];
          div_reg[i] <= wr_data[`PTM_CTRL_DIV_LSB +: 2];
        end
        if (wr_rld_lo[i]) begin
          reload_reg[i][3:0] <= wr_data;
        end
        if (wr_rld_hi[i]) begin
          reload_reg[i][7:4] <= wr_data;
        end
        // Prescaler restarts from zero when stopped so each run
        // begins with a full divided period
        if (!run_reg[i]) begin
          pre_reg[i] <= `PTM_CNT_RESET;
        end else if (src_tick[i]) begin
          pre_reg[i] <= pre_wrap[i] ? `PTM_CNT_RESET : pre_reg[i] + 8'h01;
        end
        // Stopping simply withholds count pulses; the count is kept
        if (reload_hit[i]) begin
          cnt_reg[i] <= reload_reg[i];
        end else if (uflow[i]) begin
          cnt_reg[i] <= reload_reg[i];
        end else if (count_pulse[i]) begin
          cnt_reg[i] <= cnt_reg[i] - 8'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt flags: a set in the clearing cycle wins
  // --------------------------------------------------------------------
  // The mask only gates the request, so a polling loop still sees every
  // underflow in the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_flag_reg <= 2'h0;
    end else if (ce) begin
      irq_flag_reg <= (irq_flag_reg &
                       ~({2{wr_flag}} & wr_data[1:0])) | uflow;
    end
  end

  // --------------------------------------------------------------------
  // Square wave and serial clock dividers
  // --------------------------------------------------------------------
  wire wave_uflow = wave_ch_reg ? uflow[1] : uflow[0];

  always_ff @(posedge clk) begin
    if (srst) begin
      wave_reg <= 1'b0;
      serial_reg <= 1'b0;
    end else if (ce) begin
      if (wave_uflow) begin
        wave_reg <= ~wave_reg;
      end
      // Runs whatever the pin enable says
      if (uflow[1]) begin
        serial_reg <= ~serial_reg;
      end
    end
  end

  // --------------------------------------------------------------------
  // Count read-out with high nibble hold
  // --------------------------------------------------------------------
  // Only a low read loads the hold; a high read alone returns the value
  // latched by the last low read
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_hold_reg[0] <= `PTM_NIB_RESET;
      hi_hold_reg[1] <= `PTM_NIB_RESET;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (rd_cnt_lo[i]) begin
          hi_hold_reg[i] <= cnt_reg[i][7:4];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  // --------------------------------------------------------------------
  always_comb begin
    rd_data_next = `PTM_NIB_RESET;
    unique case (addr)
      `PTM_ADDR_EVENT_CFG:
        rd_data_next = {1'b0, evt_mode_reg, evt_nr_reg, evt_pol_reg};
      `PTM_ADDR_SRC_WAVE:
        rd_data_next = {wave_ch_reg, wave_en_reg, src_sel_reg};
      `PTM_ADDR_T0_CTRL:
        rd_data_next = {div_reg[0], 1'b0, run_reg[0]};
      `PTM_ADDR_T1_CTRL:
        rd_data_next = {div_reg[1], 1'b0, run_reg[1]};
      `PTM_ADDR_T0_RLD_LO: rd_data_next = reload_reg[0][3:0];
      `PTM_ADDR_T0_RLD_HI: rd_data_next = reload_reg[0][7:4];
      `PTM_ADDR_T1_RLD_LO: rd_data_next = reload_reg[1][3:0];
      `PTM_ADDR_T1_RLD_HI: rd_data_next = reload_reg[1][7:4];
      `PTM_ADDR_T0_CNT_LO: rd_data_next = cnt_reg[0][3:0];
      `PTM_ADDR_T0_CNT_HI: rd_data_next = hi_hold_reg[0];
      `PTM_ADDR_T1_CNT_LO: rd_data_next = cnt_reg[1][3:0];
      `PTM_ADDR_T1_CNT_HI: rd_data_next = hi_hold_reg[1];
      `PTM_ADDR_IRQ_MASK: rd_data_next = {2'h0, irq_en_reg};
      `PTM_ADDR_IRQ_FLAG: rd_data_next = {2'h0, irq_flag_reg};
      default: rd_data_next = `PTM_NIB_RESET;
    endcase
  end

  // Idle read data are zero so several slaves can be ORed onto one bus
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_reg <= `PTM_NIB_RESET;
    end else if (ce) begin
      rd_data_reg <= rd_en ? rd_data_next : `PTM_NIB_RESET;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign rd_data = rd_data_reg;
  assign t0_event_mode = evt_mode_reg;
  assign t0_noise_reject_en = evt_nr_reg;
  assign t0_edge_polarity = evt_pol_reg;
  assign t0_run = run_reg[0];
  assign t1_run = run_reg[1];
  assign t0_underflow = uflow[0] & ce;
  assign t1_underflow = uflow[1] & ce;
  assign t0_irq_req = irq_flag_reg[0] & irq_en_reg[0];
  assign t1_irq_req = irq_flag_reg[1] & irq_en_reg[1];
  assign square_wave = wave_reg;
  // Plain gate, no resync: toggling the enable mid-phase can clip the
  // current half period of the wave
  assign shared_out_pin = wave_en_reg ? wave_reg : 1'b1;
  assign serial_clk = serial_reg;

endmodule

// ===== verif/ptm_timer_checker.sv
// Port-level assertions for the dual programmable timer
`timescale 1ns/100ps
`include "ptm_map.svh"

module ptm_timer_checker (
  input wire logic clk,
  input wire logic srst,
  input wire ptm_pkg::ptm_addr_t addr,
  input wire logic rd_en,
  input wire ptm_pkg::ptm_nib_t rd_data,
  input wire logic t0_run,
  input wire logic t1_run,
  input wire logic t0_underflow,
  input wire logic t1_underflow,
  input wire logic square_wave,
  input wire logic shared_out_pin,
  input wire logic serial_clk
);
  import ptm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // --------------------------------------------------------------------
  // Read-back of write-only and unused bits, and idle read data
  // --------------------------------------------------------------------
  sequence s_rd_ctrl;
    rd_en && (addr == `PTM_ADDR_T0_CTRL || addr == `PTM_ADDR_T1_CTRL);
  endsequence
  sequence s_rd_evt;
    rd_en && addr == `PTM_ADDR_EVENT_CFG;
  endsequence
  a_ctrl_strobe_zero: assert property (s_rd_ctrl |=> !rd_data[1])
    else $error("control strobe bit read back as one");
  a_evt_top_zero: assert property (s_rd_evt |=> !rd_data[3])
    else $error("unused event config bit read back as one");
  a_idle_rd_zero: assert property (!rd_en |=> rd_data == 4'h0)
    else $error("read data not zero outside a read");
  // --------------------------------------------------------------------
  // Counting and outputs
  // --------------------------------------------------------------------
  a_uf_needs_run: assert property ((!t0_underflow || t0_run) &&
    (!t1_underflow || t1_run))
    else $error("underflow while timer stopped");
  a_uf_one_cycle: assert property (t1_underflow |=> !t1_underflow)
    else $error("timer 1 underflow longer than one cycle");
  a_wave_cause: assert property ($changed(square_wave) |->
    $past(t0_underflow || t1_underflow))
    else $error("square wave moved without an underflow");
  a_serial_follow: assert property ($changed(serial_clk) ==
    $past(t1_underflow))
    else $error("serial clock does not halve timer 1 underflows");
  a_pin_gate: assert property (!shared_out_pin |-> !square_wave)
    else $error("pin low while square wave high");
endmodule

bind ptm_timer ptm_timer_checker u_ptm_timer_checker (
  .clk, .srst, .addr, .rd_en, .rd_data, .t0_run, .t1_run, .t0_underflow,
  .t1_underflow, .square_wave, .shared_out_pin, .serial_clk
);

// ===== verif/ptm_cpu_model.sv
// Processor-side bus master driving the timer registers
`timescale 1ns/100ps

module ptm_cpu_model (
  input wire logic clk,
  output ptm_pkg::ptm_addr_t addr,
  output ptm_pkg::ptm_nib_t wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire ptm_pkg::ptm_nib_t rd_data
);
  import ptm_pkg::*;
  initial begin
    addr = 16'h0000;
    wr_data = 4'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // --------------------------------------------------------------------
  // Bus cycles; a gap cycle keeps one assignment per strobe per step
  // --------------------------------------------------------------------
  task automatic wr(input ptm_addr_t a, input ptm_nib_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // Released bus shows no stale value
    wr_data <= ~d;
    addr <= ~a;
  endtask
  task automatic rd(input ptm_addr_t a, output ptm_nib_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
  endtask
endmodule

// ===== verif/ptm_timer_tb.sv
// Self-checking bench for the dual programmable timer
`timescale 1ns/100ps
`include "ptm_map.svh"

module ptm_timer_tb;
  import ptm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic slow_osc_clk = 1'b0;
  logic fast_osc_clk = 1'b0;
  logic t0_event_tick = 1'b0;
  ptm_addr_t addr;
  ptm_nib_t wr_data;
  ptm_nib_t rd_data;
  logic wr_en, rd_en, t0_event_mode, t0_noise_reject_en, t0_edge_polarity;
  logic t0_run, t1_run, t0_underflow, t1_underflow, t0_irq_req, t1_irq_req;
  logic square_wave, shared_out_pin, serial_clk, sw0, sc0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_a, r;
  int exp_reg[ptm_addr_t];
  int msk[9] = '{7, 15, 0, 0, 15, 15, 15, 15, 0};
  int ratio[4] = '{1, 4, 32, 256};

  ptm_timer u_ptm_timer (
    .clk, .srst, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .slow_osc_clk, .fast_osc_clk, .t0_event_tick, .t0_event_mode,
    .t0_noise_reject_en, .t0_edge_polarity, .t0_run, .t1_run,
    .t0_underflow, .t1_underflow, .t0_irq_req, .t1_irq_req, .square_wave,
    .shared_out_pin, .serial_clk
  );
  ptm_cpu_model u_ptm_cpu_model (
    .clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data
  );

  initial begin
    forever #12.5 clk = ~clk;
  end
  // Oscillator periods are whole clk multiples, so gaps are exact
  initial begin
    #7;
    forever #75 slow_osc_clk = ~slow_osc_clk;
  end
  // Fast oscillator runs from time zero, long settled before any use
  initial begin
    forever #50 fast_osc_clk = ~fast_osc_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // --------------------------------------------------------------------
  // Compare and bus helpers
  // --------------------------------------------------------------------
  task automatic chk_val(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_gap(input int e, input int g);
    n_tests++;
    if (g != e) begin
      fail_count++;
      $display("FAIL underflow gap expected %0d seen %0d", e, g);
    end
  endtask
  task automatic wr_m(input ptm_addr_t a, input ptm_nib_t d, input int m);
    u_ptm_cpu_model.wr(a, d);
    exp_reg[a] = d & m;
  endtask
  task automatic rd_chk(input ptm_addr_t a);
    ptm_nib_t g;
    int e;
    e = exp_reg.exists(a) ? exp_reg[a] : 0;
    u_ptm_cpu_model.rd(a, g);
    chk_val($sformatf("reg %h", a), e[7:0], {4'h0, g});
  endtask
  task automatic wait_uf1;
    do begin
      @(negedge clk);
    end while (t1_underflow !== 1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    // Worst case of the ratio sweep is about 25k cycles
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(32'h9325c48f));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk_val("pin", 1'b1, shared_out_pin);
    for (int a = 16'hffc0; a <= 16'hffcb; a++) rd_chk(a[15:0]);
    rd_chk(`PTM_ADDR_IRQ_MASK);
    rd_chk(`PTM_ADDR_IRQ_FLAG);
    rd_chk(16'hffd0);
    for (int i = 0; i < 9; i++) begin
      if (i == 2 || i == 3) continue;
      wr_m(16'hffc0 + i[15:0], 4'($urandom), msk[i]);
      rd_chk(16'hffc0 + i[15:0]);
    end
    r = exp_reg[`PTM_ADDR_EVENT_CFG];
    chk_val("pol", {7'h0, r[0]}, t0_edge_polarity);
    chk_val("nr", {7'h0, r[1]}, t0_noise_reject_en);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        r = $urandom_range(3, 0);
        wr_m(`PTM_ADDR_T1_RLD_LO, r[3:0], 15);
        wr_m(`PTM_ADDR_T1_RLD_HI, 4'h0, 15);
        wr_m(`PTM_ADDR_IRQ_MASK, {2'b00, s[0], 1'b0}, 3);
        // Wave from timer 1; pin enable and timer 1 fast source both follow s
        wr_m(`PTM_ADDR_SRC_WAVE, {1'b1, s[0], s[0], 1'b0}, 15);
        wr_m(`PTM_ADDR_T1_CTRL, {c[1:0], 2'b11}, 13);
        rd_chk(`PTM_ADDR_T1_CTRL);
        chk_val("run", 1'b1, t1_run);
        wait_uf1();
        t_a = cyc;
        sw0 = square_wave;
        sc0 = serial_clk;
        wait_uf1();
        chk_gap((r + 1) * ratio[c] * (s ? 4 : 6), cyc - t_a);
        chk_val("wave", {7'h0, ~sw0}, square_wave);
        chk_val("serial", {7'h0, ~sc0}, serial_clk);
        chk_val("pin", s ? square_wave : 1'b1, shared_out_pin);
        chk_val("irq", s[0], t1_irq_req);
        wr_m(`PTM_ADDR_T1_CTRL, 4'h0, 13);
        exp_reg[`PTM_ADDR_IRQ_FLAG] = 2;
        rd_chk(`PTM_ADDR_IRQ_FLAG);
        wr_m(`PTM_ADDR_IRQ_FLAG, 4'h2, 0);
        rd_chk(`PTM_ADDR_IRQ_FLAG);
      end
    end
    wr_m(`PTM_ADDR_T1_RLD_LO, 4'h5, 15);
    wr_m(`PTM_ADDR_T1_RLD_HI, 4'ha, 15);
    wr_m(`PTM_ADDR_T1_CTRL, 4'h2, 13);
    exp_reg[`PTM_ADDR_T1_CNT_LO] = 5;
    exp_reg[`PTM_ADDR_T1_CNT_HI] = 10;
    repeat (2) begin
      repeat (40) @(posedge clk);
      rd_chk(`PTM_ADDR_T1_CNT_LO);
      rd_chk(`PTM_ADDR_T1_CNT_HI);
    end
    wr_m(`PTM_ADDR_EVENT_CFG, 4'h4, 7);
    @(negedge clk);
    chk_val("mode", 1'b1, t0_event_mode);
    // Wave on the pin from timer 0 this time
    wr_m(`PTM_ADDR_SRC_WAVE, 4'h4, 15);
    wr_m(`PTM_ADDR_T0_RLD_LO, 4'h2, 15);
    wr_m(`PTM_ADDR_T0_RLD_HI, 4'h0, 15);
    wr_m(`PTM_ADDR_T0_CTRL, 4'h3, 13);
    sw0 = square_wave;
    for (int i = 0; i < 3; i++) begin
      repeat (30) @(posedge clk);
      t0_event_tick <= 1'b1;
      @(negedge clk);
      chk_val("event", i == 2, t0_underflow);
      chk_val("run0", 1'b1, t0_run);
      @(posedge clk);
      t0_event_tick <= 1'b0;
    end
    // Clock enable low must freeze the counter through an event tick
    @(posedge clk);
    ce <= 1'b0;
    t0_event_tick <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    t0_event_tick <= 1'b0;
    exp_reg[`PTM_ADDR_T0_CNT_LO] = 2;
    rd_chk(`PTM_ADDR_T0_CNT_LO);
    wr_m(`PTM_ADDR_IRQ_MASK, 4'h1, 3);
    @(negedge clk);
    chk_val("irq0", 1'b1, t0_irq_req);
    chk_val("wave0", {7'h0, ~sw0}, square_wave);
    chk_val("pin0", {7'h0, ~sw0}, shared_out_pin);
    wrap_up();
  end
endmodule
